/* File: pkg/remap_lock_pkg.sv */
// constants for the remap write-protection block
// assumes a single system clock and a byte-wide view of the oscillator control low byte
package remap_lock_pkg;
  localparam int          OSC_BYTE_W   = 8;
  localparam logic [7:0]  UNLOCK_KEY_A = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY_B = 8'h57;
  localparam int          LOCK_BIT     = 6;
  localparam int          ONE_WAY_BIT  = 5;
  localparam logic        LOCK_RESET   = 1'b0;
  localparam int          REMAP_REGS   = 8;
  localparam int          REMAP_W      = 16;

  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_GOT_A = 3'b010,
    KEY_OPEN  = 3'b100
  } key_state_e;
endpackage

/* File: verilog/remap_shadow.sv */
// shadow copy and mismatch monitor for the remap registers
// assumes live contents and write strobes come from the main block, same clock
`timescale 1ns/10ps
module remap_shadow
  import remap_lock_pkg::*;
#(
  parameter int NREGS = REMAP_REGS,
  parameter int WIDTH = REMAP_W
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // live image and accepted writes
  input  wire logic [NREGS*WIDTH-1:0] live,
  input  wire logic [NREGS-1:0]       wr_ok,
  input  wire logic [WIDTH-1:0]       wr_data,
  // result
  output logic                        mismatch
);
  initial begin
    if (NREGS < 1 || WIDTH < 1) $error("remap_shadow: bad size");
  end

  typedef struct packed {
    logic [NREGS*WIDTH-1:0] shadow;
    logic                   mis;
  } shadow_s;

  shadow_s st_q;
  shadow_s st_d;
  logic [NREGS-1:0] diff;

  genvar g;
  generate
    for (g = 0; g < NREGS; g++) begin : gen_cmp
      // a legal write updates both copies together, so only disturbances differ
      assign diff[g] = live[g*WIDTH +: WIDTH] != st_q.shadow[g*WIDTH +: WIDTH];
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < NREGS; i++) begin
      if (wr_ok[i]) begin
        st_d.shadow[i*WIDTH +: WIDTH] = wr_data;
      end
    end
    st_d.mis = |diff;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign mismatch = st_q.mis;
endmodule

/* File: verilog/pin_remap_write_lock.sv */
// remap register write protection: lock bit, key sequence, one-way option, shadow monitor
// assumes processor writes arrive as one-cycle strobes synchronous to CLOCK
// Summary of operation
// - while the pin map lock is set, remap register writes complete but change nothing.
// - the pin map lock is bit 6 of the oscillator control register; one blocks, zero permits.
// - the lock changes only on the single write right after keys 0x46 then 0x57 to the low byte.
// - the lock holds its value until software changes it; there is no automatic relock.
// - shadow copies of the remap registers are compared continuously; a difference requests reset.
// - with the one-way option (config bit 5) active, a set lock cannot be cleared.
// - with the one-way option active and the lock set, the key sequence has no effect.
// - in the one-way locked state only device reset clears the lock.
// - one-way option high (unprogrammed) gives one session; low allows unlimited sessions.
`timescale 1ns/10ps
module pin_remap_write_lock
  import remap_lock_pkg::*;
#(
  parameter int NREGS = REMAP_REGS,
  parameter int WIDTH = REMAP_W
) (
  // clock and reset
  input  wire logic                     CLOCK,
  input  wire logic                     NRST,
  input  wire logic                     CE,
  // oscillator control low byte writes
  input  wire logic                     OSC_WR,
  input  wire logic [OSC_BYTE_W-1:0]    OSC_WDATA,
  // oscillator configuration word
  input  wire logic [OSC_BYTE_W-1:0]    OSC_CONFIG_WORD,
  // remap register writes
  input  wire logic                     REMAP_WR,
  input  wire logic [$clog2(NREGS)-1:0] REMAP_ADDR,
  input  wire logic [WIDTH-1:0]         REMAP_WDATA,
  // disturbance injection, models upsets in the live cells
  input  wire logic                     UPSET,
  input  wire logic [WIDTH-1:0]         UPSET_MASK,
  // status and contents
  output logic                          PIN_MAP_LOCK,
  output logic [NREGS*WIDTH-1:0]        REMAP_REGS_OUT,
  output logic                          MISMATCH_RESET_REQ
);
  initial begin
    if (NREGS < 2 || WIDTH < 1) $error("pin_remap_write_lock: bad size");
    if (LOCK_BIT >= OSC_BYTE_W || ONE_WAY_BIT >= OSC_BYTE_W) $error("pin_remap_write_lock: control bit outside byte");
  end

  typedef struct packed {
    key_state_e             key;
    logic                   lock;
    // any set since reset; the one-way refusal keys off it
    logic                   ever_set;
    logic [NREGS*WIDTH-1:0] regs;
  } lock_s;

  lock_s st_q;
  lock_s st_d;
  logic  one_way;
  logic  frozen;
  logic  any_wr;
  logic  mis;
  logic [NREGS-1:0] wr_ok;

  ////////////////////////////////////////////////////////////////////////////
  assign one_way = OSC_CONFIG_WORD[ONE_WAY_BIT];
  // one-way session spent: keys and clears are both refused
  assign frozen  = one_way && st_q.lock && st_q.ever_set;
  assign any_wr  = OSC_WR || REMAP_WR;

  genvar g;
  generate
    for (g = 0; g < NREGS; g++) begin : gen_wr
      // gated by last cycle's lock, so a same-cycle unlock write does not open it
      assign wr_ok[g] = REMAP_WR && !st_q.lock && (REMAP_ADDR == ($clog2(NREGS))'(g));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    unique case (st_q.key)
      KEY_IDLE: begin
        if (OSC_WR && OSC_WDATA == UNLOCK_KEY_A && !frozen) begin
          st_d.key = KEY_GOT_A;
        end
      end
      KEY_GOT_A: begin
        if (OSC_WR && OSC_WDATA == UNLOCK_KEY_B) begin
          st_d.key = KEY_OPEN;
        end else if (any_wr) begin
          st_d.key = KEY_IDLE;
        end
      end
      KEY_OPEN: begin
        if (OSC_WR) begin
          // set always allowed; clear refused once one-way has latched
          if (!(frozen && !OSC_WDATA[LOCK_BIT])) begin
            st_d.lock = OSC_WDATA[LOCK_BIT];
          end
          st_d.key = KEY_IDLE;
        end else if (REMAP_WR) begin
          // a remap write closes the session unused; keys are never queued
          st_d.key = KEY_IDLE;
        end
      end
      default: st_d.key = KEY_IDLE;
    endcase
    if (st_d.lock) begin
      st_d.ever_set = 1'b1;
    end
    for (int i = 0; i < NREGS; i++) begin
      if (wr_ok[i]) begin
        st_d.regs[i*WIDTH +: WIDTH] = REMAP_WDATA;
      end
    end
    // upsets only reach register 0, enough to exercise the shadow compare
    if (UPSET) begin
      st_d.regs[WIDTH-1:0] = st_d.regs[WIDTH-1:0] ^ UPSET_MASK;
    end
  end

  // lock has no timer: it only moves on the keyed write
  // reset also clears the detector, so a cut key sequence never survives it
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_q.key      <= KEY_IDLE;
      st_q.lock     <= LOCK_RESET;
      st_q.ever_set <= 1'b0;
      st_q.regs     <= '0;
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  remap_shadow #(
    .NREGS (NREGS),
    .WIDTH (WIDTH)
  ) remap_shadow_inst (
    .clock    (CLOCK),
    .nrst     (NRST),
    .ce       (CE),
    .live     (st_q.regs),
    .wr_ok    (wr_ok),
    .wr_data  (REMAP_WDATA),
    .mismatch (mis)
  );

  assign PIN_MAP_LOCK       = st_q.lock;
  assign REMAP_REGS_OUT     = st_q.regs;
  assign MISMATCH_RESET_REQ = mis;

  ////////////////////////////////////////////////////////////////////////////
  // remap write gating, lock stability, key abort, shadow upset and one-way checks
  AST_LOCKED_WRITE_IGNORED: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && REMAP_WR && st_q.lock && !UPSET) |=> $stable(REMAP_REGS_OUT))
    else $error("remap write took effect while locked");

  AST_UNLOCKED_WRITE_STORES: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && REMAP_WR && !st_q.lock && !UPSET && REMAP_ADDR == 0) |=> REMAP_REGS_OUT[WIDTH-1:0] == $past(REMAP_WDATA))
    else $error("unlocked remap write not stored");

  AST_LOCK_NEEDS_KEYS: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key != KEY_OPEN) |=> $stable(PIN_MAP_LOCK))
    else $error("lock changed without key sequence");

  AST_LOCK_HOLDS: assert property (@(posedge CLOCK) disable iff (!NRST)
    (!CE || !OSC_WR) |=> $stable(PIN_MAP_LOCK))
    else $error("lock changed without a write");

  AST_SHADOW_FLAGS_UPSET: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && UPSET && UPSET_MASK != '0 && !REMAP_WR) ##1 CE |=> MISMATCH_RESET_REQ)
    else $error("upset not reported");

  AST_ONE_WAY_NO_CLEAR: assert property (@(posedge CLOCK) disable iff (!NRST)
    (one_way && PIN_MAP_LOCK && st_q.ever_set && $stable(one_way)) |=> PIN_MAP_LOCK)
    else $error("one-way lock was cleared");

  AST_ONE_WAY_KEYS_DEAD: assert property (@(posedge CLOCK) disable iff (!NRST)
    (frozen && st_q.key == KEY_IDLE) |=> st_q.key == KEY_IDLE)
    else $error("key detector advanced while frozen");

  AST_KEY_ABORT: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key == KEY_GOT_A && REMAP_WR && !OSC_WR) |=> st_q.key == KEY_IDLE)
    else $error("intervening write did not abort keys");

  AST_MULTI_SESSION: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && !one_way && st_q.key == KEY_OPEN && OSC_WR && !OSC_WDATA[LOCK_BIT]) |=> !PIN_MAP_LOCK)
    else $error("programmed option refused unlock");

  // key sequence and session close
  AST_KEY_A_TAKEN: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key == KEY_IDLE && OSC_WR && OSC_WDATA == UNLOCK_KEY_A && !frozen) |=> st_q.key == KEY_GOT_A)
    else $error("first key not taken");

  AST_KEY_B_OPENS: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key == KEY_GOT_A && OSC_WR && OSC_WDATA == UNLOCK_KEY_B) |=> st_q.key == KEY_OPEN)
    else $error("second key did not open the session");

  AST_WRONG_KEY_RESTARTS: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key == KEY_GOT_A && OSC_WR && OSC_WDATA != UNLOCK_KEY_B)
    |=> (st_q.key == KEY_IDLE && $stable(PIN_MAP_LOCK)))
    else $error("wrong second key kept the detector armed");

  AST_OPEN_SETS_LOCK: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key == KEY_OPEN && OSC_WR && OSC_WDATA[LOCK_BIT]) |=> PIN_MAP_LOCK)
    else $error("lock write with bit set did not lock");

  AST_OPEN_CLEARS_LOCK: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key == KEY_OPEN && OSC_WR && !OSC_WDATA[LOCK_BIT] && !frozen) |=> !PIN_MAP_LOCK)
    else $error("open session could not clear the lock");

  AST_SINGLE_WRITE_CLOSES: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && st_q.key == KEY_OPEN && OSC_WR) |=> st_q.key == KEY_IDLE)
    else $error("session stayed open after the lock write");

  // one-way option
  AST_FROZEN_REMAP_STABLE: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && frozen && !UPSET) |=> $stable(REMAP_REGS_OUT))
    else $error("remap contents moved in the one-way locked state");

  AST_ONE_SESSION_ALLOWED: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CE && one_way && !PIN_MAP_LOCK && st_q.key == KEY_IDLE && OSC_WR && OSC_WDATA == UNLOCK_KEY_A)
    |=> st_q.key == KEY_GOT_A)
    else $error("one-way option refused its first session");
endmodule

/* File: bench/pin_remap_write_lock_test.sv */
// self-checking bench for the remap write-protection block
// assumes default NREGS/WIDTH; inputs change on falling edges only
`timescale 1ns/10ps
module pin_remap_write_lock_test;
  import remap_lock_pkg::*;
  localparam int         PERIOD  = 50;
  localparam logic [7:0] LOCK_ON = 8'h01 << LOCK_BIT;
  localparam logic [7:0] ONE_WAY = 8'h01 << ONE_WAY_BIT;
  logic         clock       = 1'b0;
  logic         nrst        = 1'b0;
  logic         osc_wr      = 1'b0;
  logic         remap_wr    = 1'b0;
  logic         upset       = 1'b0;
  logic         ce          = 1'b1;
  logic [7:0]   osc_wdata   = 8'h00;
  logic [7:0]   cfg         = 8'h00;
  logic [2:0]   remap_addr  = 3'h0;
  logic [15:0]  remap_wdata = 16'h0000;
  logic [15:0]  upset_mask  = 16'h0000;
  logic         lock;
  logic         mism;
  logic [127:0] regs;
  int           failures    = 0;
  int           num_checks  = 0;

  always #(PERIOD/2) clock = ~clock;

  pin_remap_write_lock pin_remap_write_lock_inst (
    .CLOCK(clock), .NRST(nrst), .CE(ce), .OSC_WR(osc_wr), .OSC_WDATA(osc_wdata),
    .OSC_CONFIG_WORD(cfg), .REMAP_WR(remap_wr), .REMAP_ADDR(remap_addr),
    .REMAP_WDATA(remap_wdata), .UPSET(upset), .UPSET_MASK(upset_mask),
    .PIN_MAP_LOCK(lock), .REMAP_REGS_OUT(regs), .MISMATCH_RESET_REQ(mism)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  // strobes drop on the next falling edge, so calls never collide in one step
  task automatic osc(input logic [7:0] d);
    @(negedge clock);
    osc_wr = 1'b1;
    osc_wdata = d;
    @(negedge clock);
    osc_wr = 1'b0;
  endtask

  task automatic rmp(input logic [2:0] a, input logic [15:0] d);
    @(negedge clock);
    remap_wr = 1'b1;
    remap_addr = a;
    remap_wdata = d;
    @(negedge clock);
    remap_wr = 1'b0;
    wait_n(2);
  endtask

  task automatic set_lock(input logic [7:0] d);
    osc(UNLOCK_KEY_A);
    osc(UNLOCK_KEY_B);
    osc(d);
    wait_n(2);
  endtask

  task automatic do_reset;
    nrst = 1'b0;
    wait_n(5);
    nrst = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sessions;
    chk(lock, 1'b0, "lock after reset");
    chk(regs, '0, "regs after reset");
    rmp(3'h3, 16'hA5C3);
    chk(regs[48+:16], 16'hA5C3, "open write lost");
    set_lock(LOCK_ON);
    chk(lock, 1'b1, "lock not set");
    rmp(3'h3, 16'h1234);
    wait_n(20);
    chk(regs[48+:16], 16'hA5C3, "locked write took");
    chk(lock, 1'b1, "lock fell");
    set_lock(8'h00);
    chk(lock, 1'b0, "lock not cleared");
    rmp(3'h3, 16'h1234);
    chk(regs[48+:16], 16'h1234, "reopened write lost");
    set_lock(LOCK_ON);
    chk(lock, 1'b1, "second session lock");
    set_lock(8'h00);
    chk(lock, 1'b0, "second session unlock");
  endtask

  task automatic t_broken_keys;
    osc(UNLOCK_KEY_A);
    rmp(3'h0, 16'h0F0F);
    osc(UNLOCK_KEY_B);
    osc(LOCK_ON);
    wait_n(2);
    chk(lock, 1'b0, "interrupted keys");
    osc(UNLOCK_KEY_A);
    osc(8'h55);
    osc(LOCK_ON);
    wait_n(2);
    chk(lock, 1'b0, "wrong second key");
    ce = 1'b0;
    set_lock(LOCK_ON);
    ce = 1'b1;
    chk(lock, 1'b0, "keys taken with clock enable low");
  endtask

  task automatic t_one_way;
    do_reset();
    cfg = ONE_WAY;
    set_lock(LOCK_ON);
    chk(lock, 1'b1, "one-way set");
    set_lock(8'h00);
    chk(lock, 1'b1, "one-way cleared");
    rmp(3'h1, 16'hBEEF);
    chk(regs[16+:16], 16'h0000, "one-way write took");
    do_reset();
    chk(lock, 1'b0, "reset kept lock");
    rmp(3'h1, 16'hBEEF);
    chk(regs[16+:16], 16'hBEEF, "write after reset");
  endtask

  task automatic t_upset;
    chk(mism, 1'b0, "mismatch after legal writes");
    @(negedge clock);
    upset = 1'b1;
    upset_mask = 16'h0101;
    @(negedge clock);
    upset = 1'b0;
    wait_n(2);
    chk(mism, 1'b1, "upset not seen");
    do_reset();
    chk(mism, 1'b0, "mismatch after reset");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_sessions();
    t_broken_keys();
    t_one_way();
    t_upset();
    report_and_stop();
  end

  // tests take about 140 cycles; a hang is cut well past that
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    report_and_stop();
  end
endmodule
